// *** core/pgp_defines.svh ***
// register offsets, reset values and widths for the port pin control block
// assumes inclusion by bare name from design files under core/
`ifndef PGP_DEFINES_SVH
`define PGP_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define PGP_OFS_LATCH    12'h000
`define PGP_OFS_DIR      12'h004
`define PGP_OFS_ANALOG_SEL 12'h008
`define PGP_OFS_PULLUP   12'h00C
`define PGP_OFS_ROUTE    12'h010
`define PGP_OFS_AOUT     12'h014
`define PGP_OFS_PINS     12'h018

// ==========================================================================
// reset values (six pins)
`define PGP_RST_LATCH    6'h00
`define PGP_RST_DIR      6'h3F
`define PGP_RST_ANALOG_SEL 6'h3F
`define PGP_RST_PULLUP   6'h00
`define PGP_RST_ROUTE    6'h00
`define PGP_RST_AOUT     6'h00

`define PGP_NPINS        6
`define PGP_ADDR_W       12
`define PGP_DATA_W       32

`endif

// *** core/pgp_pkg.sv ***
// types shared by the port pin control block
// assumes pgp_defines.svh is on the include path
`include "pgp_defines.svh"
package pgp_pkg;
    typedef logic [`PGP_NPINS-1:0] pgp_pins_t;
    // register picked out by an apb address
    typedef enum {
        sel_latch,
        sel_dir,
        sel_analog,
        sel_pullup,
        sel_route,
        sel_aout,
        sel_pins,
        sel_none
    } pgp_sel_e;
endpackage

// *** core/pgp_sync_if.sv ***
// interface carrying raw pin levels into the synchroniser and clean levels back
// assumes one clock domain, pclk
interface pgp_sync_if;
    pgp_pkg::pgp_pins_t raw;
    pgp_pkg::pgp_pins_t clean;
    modport owner (output raw, input clean);
    modport sync  (input raw, output clean);
endinterface

// *** core/pgp_pin_sync.sv ***
// three-stage synchroniser for the port pin inputs
// assumes pins are asynchronous to pclk
`include "pgp_defines.svh"

module pgp_pin_sync #(
    parameter int NPINS = `PGP_NPINS
) (
    input  wire logic pclk,
    input  wire logic presetn,
    pgp_sync_if.sync  sif
);
    // ======================================================================
    // checks
    if (NPINS < 1 || NPINS > `PGP_DATA_W) begin : g_bad
        $error("pgp_pin_sync: NPINS out of range");
    end

    logic [NPINS-1:0] s1_r, s2_r, s3_r, clean_r;
    logic [NPINS-1:0] s1_nxt, s2_nxt, s3_nxt, clean_nxt;

    // ======================================================================
    // next state
    // change taken only once second and third stages agree
    always_comb begin
        s1_nxt    = sif.raw;
        s2_nxt    = s1_r;
        s3_nxt    = s2_r;
        clean_nxt = clean_r;
        for (int i = 0; i < NPINS; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                clean_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            clean_r <= '0;
        end else begin
            s1_r    <= s1_nxt;
            s2_r    <= s2_nxt;
            s3_r    <= s3_nxt;
            clean_r <= clean_nxt;
        end
    end

    assign sif.clean = clean_r;
endmodule

// *** core/pgp_port.sv ***
// six-pin general purpose port: latch, direction, analog select, pull-up,
// peripheral routing and analog output override, reached over APB
// assumes one clock pclk, asynchronous active-low presetn, pins asynchronous
//
// Implementation choices: the APB register port and the address map.
`include "pgp_defines.svh"

// Summary of operation
// - analog-select set makes digital reads zero; input goes to analog side
// - analog-select never touches output drive or output source
// - output pin with analog-select set keeps driving its digital value
// - analog-select bits reset set; software clears them for digital input
// - one independent pull-up enable bit per pin in its own register
// - after reset each pin's output source is its port latch value, with the driver off
// - other sources reach a pin only via routing select or analog output
// - routed digital outputs still drive analog-input pins
// - direction bit set disables driver; clear enables it
// - analog output overrides driver, input, pull-up; reads return zero
module pgp_port #(
    parameter int NPINS = `PGP_NPINS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NPINS-1:0]  port_a_pins_in,
    output logic      [NPINS-1:0]  port_a_pins_out,
    output logic      [NPINS-1:0]  port_a_pins_oe,
    output logic      [NPINS-1:0]  pull_up_on,
    output logic      [NPINS-1:0]  analog_in_en,
    output logic      [NPINS-1:0]  analog_out_en,
    input  wire logic [NPINS-1:0]  periph_out
);
    // ======================================================================
    // checks
    if (NPINS != `PGP_NPINS) begin : g_bad
        $error("pgp_port: only six pins supported");
    end

    // ======================================================================
    // registers
    pgp_pkg::pgp_pins_t latch_r;
    pgp_pkg::pgp_pins_t latch_nxt;
    pgp_pkg::pgp_pins_t dir_r;
    pgp_pkg::pgp_pins_t dir_nxt;
    pgp_pkg::pgp_pins_t analog_sel_r;
    pgp_pkg::pgp_pins_t analog_sel_nxt;
    pgp_pkg::pgp_pins_t pullup_r;
    pgp_pkg::pgp_pins_t pullup_nxt;
    pgp_pkg::pgp_pins_t route_r;
    pgp_pkg::pgp_pins_t route_nxt;
    pgp_pkg::pgp_pins_t aout_r;
    pgp_pkg::pgp_pins_t aout_nxt;
    logic [31:0]        prdata_r;
    logic [31:0]        prdata_nxt;
    logic               pready_r;
    logic               pready_nxt;
    logic               pslverr_r;
    logic               pslverr_nxt;
    pgp_pkg::pgp_pins_t pout_r;
    pgp_pkg::pgp_pins_t pout_nxt;
    pgp_pkg::pgp_pins_t poe_r;
    pgp_pkg::pgp_pins_t poe_nxt;
    pgp_pkg::pgp_pins_t pu_r;
    pgp_pkg::pgp_pins_t pu_nxt;
    pgp_pkg::pgp_pins_t ain_r;
    pgp_pkg::pgp_pins_t ain_nxt;
    pgp_pkg::pgp_pins_t aoen_r;
    pgp_pkg::pgp_pins_t aoen_nxt;
    pgp_pkg::pgp_pins_t pin_read;
    pgp_pkg::pgp_sel_e  sel;

    pgp_sync_if sif ();
    assign sif.raw = port_a_pins_in;

    pgp_pin_sync #(.NPINS(NPINS)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    function automatic logic [31:0] widen(input pgp_pkg::pgp_pins_t v);
        widen = {26'h0000000, v};
    endfunction

    // ======================================================================
    // address decode
    // one decode shared by the read and write paths
    function automatic pgp_pkg::pgp_sel_e decode(input logic [`PGP_ADDR_W-1:0] a);
        case (a)
            `PGP_OFS_LATCH:      decode = pgp_pkg::sel_latch;
            `PGP_OFS_DIR:        decode = pgp_pkg::sel_dir;
            `PGP_OFS_ANALOG_SEL: decode = pgp_pkg::sel_analog;
            `PGP_OFS_PULLUP:     decode = pgp_pkg::sel_pullup;
            `PGP_OFS_ROUTE:      decode = pgp_pkg::sel_route;
            `PGP_OFS_AOUT:       decode = pgp_pkg::sel_aout;
            `PGP_OFS_PINS:       decode = pgp_pkg::sel_pins;
            default:             decode = pgp_pkg::sel_none;
        endcase
    endfunction

    assign sel = decode(paddr);

    // ======================================================================
    // pin read path
    // analog reads zero
    // synchronised level
    // outputs read back their own level, so read-modify-write on an
    // analog pin clears its latch bit: a known hazard of this port
    assign pin_read = sif.clean & ~analog_sel_r & ~aout_r;

    // ======================================================================
    // apb slave: one wait-free access phase, pready in the first access cycle only
    wire access = psel && penable;
    wire wr     = access && pwrite;

    always_comb begin
        latch_nxt   = latch_r;
        dir_nxt     = dir_r;
        analog_sel_nxt = analog_sel_r;
        pullup_nxt  = pullup_r;
        route_nxt   = route_r;
        aout_nxt    = aout_r;
        prdata_nxt  = 32'h00000000;
        pready_nxt  = psel && !penable;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            unique case (sel)
                pgp_pkg::sel_latch:  prdata_nxt = widen(latch_r);
                pgp_pkg::sel_dir:    prdata_nxt = widen(dir_r);
                pgp_pkg::sel_analog: prdata_nxt = widen(analog_sel_r);
                pgp_pkg::sel_pullup: prdata_nxt = widen(pullup_r);
                pgp_pkg::sel_route:  prdata_nxt = widen(route_r);
                pgp_pkg::sel_aout:   prdata_nxt = widen(aout_r);
                pgp_pkg::sel_pins:   prdata_nxt = widen(pin_read);
                pgp_pkg::sel_none:   pslverr_nxt = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (sel)
                pgp_pkg::sel_latch:  latch_nxt      = pwdata[NPINS-1:0];
                pgp_pkg::sel_dir:    dir_nxt        = pwdata[NPINS-1:0];
                pgp_pkg::sel_analog: analog_sel_nxt = pwdata[NPINS-1:0];
                pgp_pkg::sel_pullup: pullup_nxt     = pwdata[NPINS-1:0];
                pgp_pkg::sel_route:  route_nxt      = pwdata[NPINS-1:0];
                pgp_pkg::sel_aout:   aout_nxt       = pwdata[NPINS-1:0];
                // pin word is read-only; unmapped words drop the write
                pgp_pkg::sel_pins,
                pgp_pkg::sel_none: begin
                end
            endcase
        end
    end

    // ======================================================================
    // pin drive path, registered
    always_comb begin
        pout_nxt = (route_r & periph_out) | (~route_r & latch_r);
        poe_nxt  = ~dir_r & ~aout_r;
        pout_nxt = pout_nxt & ~aout_r;
        pu_nxt   = pullup_r & ~aout_r;
        ain_nxt  = analog_sel_r | aout_r;
        aoen_nxt = aout_r;
    end

    // ======================================================================
    // control registers and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_r      <= `PGP_RST_LATCH;
            dir_r        <= `PGP_RST_DIR;
            analog_sel_r <= `PGP_RST_ANALOG_SEL;
            pullup_r     <= `PGP_RST_PULLUP;
            route_r      <= `PGP_RST_ROUTE;
            aout_r       <= `PGP_RST_AOUT;
            prdata_r     <= 32'h00000000;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
        end else begin
            latch_r      <= latch_nxt;
            dir_r        <= dir_nxt;
            analog_sel_r <= analog_sel_nxt;
            pullup_r     <= pullup_nxt;
            route_r      <= route_nxt;
            aout_r       <= aout_nxt;
            prdata_r     <= prdata_nxt;
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
        end
    end

    // ======================================================================
    // pin side registers
    // held safe in reset: no driver, no pull-up, input handed to analog side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pout_r <= '0;
            poe_r  <= '0;
            pu_r   <= '0;
            ain_r  <= `PGP_RST_ANALOG_SEL;
            aoen_r <= '0;
        end else begin
            pout_r <= pout_nxt;
            poe_r  <= poe_nxt;
            pu_r   <= pu_nxt;
            ain_r  <= ain_nxt;
            aoen_r <= aoen_nxt;
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign port_a_pins_out = pout_r;
    assign port_a_pins_oe  = poe_r;
    assign pull_up_on      = pu_r;
    assign analog_in_en    = ain_r;
    assign analog_out_en   = aoen_r;
endmodule

// *** test/pgp_port_sva.sv ***
// checker for the port pin control block, sees top ports only
// assumes one clock pclk and async active-low presetn
module pgp_port_sva #(
    parameter int NPINS = 6
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [NPINS-1:0] port_a_pins_in,
    input wire logic [NPINS-1:0] port_a_pins_out,
    input wire logic [NPINS-1:0] port_a_pins_oe,
    input wire logic [NPINS-1:0] pull_up_on,
    input wire logic [NPINS-1:0] analog_in_en,
    input wire logic [NPINS-1:0] analog_out_en,
    input wire logic [NPINS-1:0] periph_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // pin relations
    chk_aout_no_drive: assert property ((analog_out_en & port_a_pins_oe) == '0)
        else $error("driver on with analog output");
    chk_aout_no_pull: assert property ((analog_out_en & pull_up_on) == '0)
        else $error("pull-up on with analog output");
    chk_aout_ain: assert property ((analog_out_en & ~analog_in_en) == '0)
        else $error("analog output without analog input");
    chk_aout_out_low: assert property ((analog_out_en & port_a_pins_out) == '0)
        else $error("analog output pin drives data");
    chk_reset_vals: assert property ($rose(presetn) |->
        analog_in_en == {NPINS{1'b1}} && port_a_pins_oe == '0)
        else $error("wrong pin state after reset");
    // ==========================================================
    // bus relations
    chk_ready_access: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
        else $error("no answer in first access cycle");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready not a single access pulse");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("read data outside answer");
    cov_write: cover property (pready && pwrite);
    cov_error: cover property (pready && pslverr);
    cov_aout: cover property (analog_out_en != '0);
endmodule

bind pgp_port pgp_port_sva #(
    .NPINS(NPINS)
) u_sva (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .port_a_pins_in  (port_a_pins_in),
    .port_a_pins_out (port_a_pins_out),
    .port_a_pins_oe  (port_a_pins_oe),
    .pull_up_on      (pull_up_on),
    .analog_in_en    (analog_in_en),
    .analog_out_en   (analog_out_en),
    .periph_out      (periph_out)
);

// *** test/pgp_pin_model.sv ***
// external circuitry on the six pins
// assumes drive priority: device driver, outside driver, pull-up
module pgp_pin_model (
    input  wire logic         pclk,
    input  pgp_pkg::pgp_pins_t pins_out,
    input  pgp_pkg::pgp_pins_t pins_oe,
    input  pgp_pkg::pgp_pins_t pull_up,
    input  pgp_pkg::pgp_pins_t ext_en,
    input  pgp_pkg::pgp_pins_t ext_val,
    output pgp_pkg::pgp_pins_t level
);
    timeunit 1ns;
    timeprecision 1ps;
    // floating pins wander so a stale value never passes
    pgp_pkg::pgp_pins_t float_r = 6'h15;
    always @(posedge pclk) float_r <= ~float_r;
    always_comb
        for (int i = 0; i < 6; i++)
            level[i] = pins_oe[i] ? pins_out[i] : ext_en[i] ? ext_val[i] :
                       pull_up[i] ? 1'b1 : float_r[i];
endmodule

// *** test/tb_pgp_port.sv ***
// bench for the port pin control block over APB
// assumes pgp_defines.svh on the include path
`include "pgp_defines.svh"
module tb_pgp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    pgp_pkg::pgp_pins_t pin_in, pin_out, pin_oe, pull, ain, aout;
    pgp_pkg::pgp_pins_t periph = '0, ext_en = '0, ext_val = '0;
    int errors = 0, cmp_count = 0;
    logic [11:0] ofs [6] = '{`PGP_OFS_LATCH, `PGP_OFS_DIR, `PGP_OFS_ANALOG_SEL,
                             `PGP_OFS_PULLUP, `PGP_OFS_ROUTE, `PGP_OFS_AOUT};
    logic [5:0] rstv [6] = '{6'h00, 6'h3F, 6'h3F, 6'h00, 6'h00, 6'h00};
    always #4 pclk = ~pclk;
    pgp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_pins_in(pin_in), .port_a_pins_out(pin_out),
        .port_a_pins_oe(pin_oe), .pull_up_on(pull), .analog_in_en(ain),
        .analog_out_en(aout), .periph_out(periph));
    pgp_pin_model ext (.pclk(pclk), .pins_out(pin_out), .pins_oe(pin_oe), .pull_up(pull),
        .ext_en(ext_en), .ext_val(ext_val), .level(pin_in));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state limit here: only the watchdog ends a hung access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(0, a, '0);
        chk(nm, e, rdat);
    endtask
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        ext_en <= '1;
        ext_val <= 6'h3F;
        // ==========================================================
        // reset values, analog read masking
        for (int i = 0; i < 6; i++) rd(ofs[i], {26'h0, rstv[i]}, "reset value");
        repeat (8) @(posedge pclk);
        rd(`PGP_OFS_PINS, 32'h0, "analog pins");
        apb(1, `PGP_OFS_ANALOG_SEL, 32'h0);
        repeat (8) @(posedge pclk);
        rd(`PGP_OFS_PINS, 32'h3F, "digital pins");
        ext_en <= '0;
        apb(1, `PGP_OFS_LATCH, 32'h2A);
        apb(1, `PGP_OFS_DIR, 32'h0);
        apb(1, `PGP_OFS_ANALOG_SEL, 32'h3F);
        settle();
        chk("drive", 6'h3F, pin_oe);
        chk("latch out", 6'h2A, pin_out);
        rd(`PGP_OFS_PINS, 32'h0, "driven analog pins");
        @(posedge pclk);
        periph <= 6'h05;
        apb(1, `PGP_OFS_ROUTE, 32'h0F);
        settle();
        chk("routed out", 6'h25, pin_out);
        chk("routed drive", 6'h3F, pin_oe);
        apb(1, `PGP_OFS_ANALOG_SEL, 32'h0);
        repeat (8) @(posedge pclk);
        rd(`PGP_OFS_PINS, 32'h25, "output readback");
        apb(1, `PGP_OFS_ROUTE, 32'h0);
        settle();
        chk("latch again", 6'h2A, pin_out);
        apb(1, `PGP_OFS_DIR, 32'h3F);
        apb(1, `PGP_OFS_PULLUP, 32'h15);
        settle();
        chk("released", 6'h00, pin_oe);
        chk("pull-up", 6'h15, pull);
        repeat (8) @(posedge pclk);
        apb(0, `PGP_OFS_PINS, '0);
        chk("pulled pins", 32'h15, rdat & 32'h15);
        apb(1, `PGP_OFS_DIR, 32'h0);
        apb(1, `PGP_OFS_AOUT, 32'h01);
        settle();
        chk("aout drive", 6'h3E, pin_oe);
        chk("aout pull", 6'h14, pull);
        chk("aout input", 6'h01, ain);
        chk("aout enable", 6'h01, aout);
        apb(0, `PGP_OFS_PINS, '0);
        chk("aout read", 32'h0, rdat & 32'h1);
        apb(1, 12'h020, 32'h3F);
        chk("write error", 1'b1, err);
        rd(12'h020, 32'h0, "unmapped read");
        chk("read error", 1'b1, err);
        apb(1, `PGP_OFS_PINS, 32'h3F);
        chk("pins write error", 1'b0, err);
        // ==========================================================
        // reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`PGP_OFS_ANALOG_SEL, 32'h3F, "analog select after reset");
        chk("reset analog in", 6'h3F, ain);
        chk("reset aout", 6'h00, aout);
        apb(1, `PGP_OFS_LATCH, 32'h15);
        apb(1, `PGP_OFS_DIR, 32'h0);
        settle();
        chk("latch after reset", 6'h15, pin_out);
        chk("drive after reset", 6'h3F, pin_oe);
        complete_run();
    end
endmodule
